// File: core/buf_page_prog_host.sv
// Host sequencer issuing buffer-to-page program commands to a serial flash.
// Assumes the flash samples on SCK rise (mode 0); user supplies write data
// as a valid/ready byte stream. Busy is covered by waiting the maximum
// self-timed duration, since status readout is not part of this block.
//
// Contract
// - 83h/86h: buffer program with built-in erase
// - 264 mode: 4 dummy, page, 9 dummy
// - 256 mode: 5 dummy, page, 8 dummy
// - 256 mode 88h/89h/02h: short layout, confirm
// - Host pre-erases page before 88h/89h (not done here: 88h/89h is sent with no erase first)
// - 82h/85h: load buffer, erase, program
// - 264 mode: 4 dummy, page, 9-bit start
// - 256 mode: page then 8-bit start
// - 02h: 1 to page-size bytes, no erase
// - CS rises only after whole bytes
`timescale 1ns/1ps
module buf_page_prog_host #(
   parameter int ERASE_PLUS_PROGRAM_TIME_US = 40000,
   parameter int PAGE_PROGRAM_TIME_US = 4000,
   parameter int PER_BYTE_PROGRAM_TIME_US = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic binary_mode,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_kind,
   input wire logic cmd_buf_two,
   input wire logic [10:0] page_number_bits,
   input wire logic [8:0] cmd_start_addr,
   input wire logic [8:0] cmd_len,
   input wire logic data_valid,
   output logic data_ready,
   input wire logic [7:0] data_byte,
   output logic cmd_done,
   output logic cmd_reject,
   output logic flash_busy,
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_mosi
);
   localparam int EP_CYC =
      ERASE_PLUS_PROGRAM_TIME_US * 1000 / flash_prog_pkg::CLK_PERIOD_NS;
   localparam int P_CYC =
      PAGE_PROGRAM_TIME_US * 1000 / flash_prog_pkg::CLK_PERIOD_NS;
   localparam int BP_CYC =
      PER_BYTE_PROGRAM_TIME_US * 1000 / flash_prog_pkg::CLK_PERIOD_NS;

   typedef enum logic [2:0] {ST_IDLE, ST_HEAD, ST_DATA, ST_END, ST_WAIT}
      state_e;

   // Page number and low address packed into the 24 address bits.
   // The binary layout is the 19-bit linear address for every command.
   function automatic logic [23:0] build_addr(input logic bin,
      input logic [10:0] page, input logic [8:0] low);
      logic [23:0] a;
      if (bin) begin
         a = {5'h00, page, low[7:0]};
      end else begin
         a = {4'h0, page, low};
      end
      return a;
   endfunction

   function automatic logic [7:0] pick_opcode(input logic [1:0] kind,
      input logic two);
      logic [7:0] op;
      unique case (kind)
         flash_prog_pkg::KIND_PROG_ERASE:
            op = two ? flash_prog_pkg::OP_PROG_ERASE_B2 :
                       flash_prog_pkg::OP_PROG_ERASE_B1;
         flash_prog_pkg::KIND_PROG_NOERASE:
            op = two ? flash_prog_pkg::OP_PROG_NOERASE_B2 :
                       flash_prog_pkg::OP_PROG_NOERASE_B1;
         flash_prog_pkg::KIND_LOAD_PROG:
            op = two ? flash_prog_pkg::OP_LOAD_PROG_B2 :
                       flash_prog_pkg::OP_LOAD_PROG_B1;
         flash_prog_pkg::KIND_BYTE_PROG:
            op = flash_prog_pkg::OP_BYTE_PROG;
      endcase
      return op;
   endfunction

   state_e state_r, state_nxt;
   logic [1:0] kind_r, kind_nxt;
   logic [7:0] op_r, op_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic [1:0] idx_r, idx_nxt;
   logic [8:0] len_r, len_nxt;
   logic [8:0] cnt_r, cnt_nxt;
   logic [23:0] wait_r, wait_nxt;
   logic cs_n_r, cs_n_nxt;
   logic done_r, done_nxt;
   logic rej_r, rej_nxt;
   logic tx_valid, tx_ready;
   logic [7:0] tx_byte;
   logic take, has_data, len_bad;
   logic [8:0] page_size;

   spi_byte_tx u_tx (
      .core_clk(core_clk),
      .rst(rst),
      .tx_valid(tx_valid),
      .tx_byte(tx_byte),
      .tx_ready(tx_ready),
      .spi_sck(spi_sck),
      .spi_mosi(spi_mosi)
   );

   assign cmd_ready = (state_r == ST_IDLE);
   assign take = cmd_valid && cmd_ready;
   assign has_data = cmd_kind[1];
   assign page_size = binary_mode ? flash_prog_pkg::PAGE_BYTES_BIN :
                                    flash_prog_pkg::PAGE_BYTES_STD;
   // For 82h/85h and 02h, zero bytes or more than one page is refused before CS falls
   assign len_bad = has_data &&
                    (cmd_len == 9'h000 || cmd_len > page_size);

   always_comb begin
      tx_valid = 1'b0;
      tx_byte = op_r;
      data_ready = 1'b0;
      if (state_r == ST_HEAD) begin
         tx_valid = 1'b1;
         unique case (idx_r)
            2'h0: tx_byte = op_r;
            2'h1: tx_byte = addr_r[23:16];
            2'h2: tx_byte = addr_r[15:8];
            2'h3: tx_byte = addr_r[7:0];
         endcase
      end else if (state_r == ST_DATA) begin
         // Stream stalls until the shifter frees up
         tx_valid = data_valid;
         tx_byte = data_byte;
         data_ready = tx_ready;
      end
   end

   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      idx_nxt = idx_r;
      len_nxt = len_r;
      cnt_nxt = cnt_r;
      wait_nxt = wait_r;
      cs_n_nxt = cs_n_r;
      done_nxt = 1'b0;
      rej_nxt = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            if (take) begin
               if (len_bad) begin
                  rej_nxt = 1'b1;
               end else begin
                  // 83h/86h, 88h/89h, 82h/85h or 02h by kind and buffer
                  op_nxt = pick_opcode(cmd_kind, cmd_buf_two);
                  // Dummy bits in front of the page, start or dummy after
                  addr_nxt = build_addr(binary_mode, page_number_bits,
                     has_data ? cmd_start_addr : 9'h000);
                  kind_nxt = cmd_kind;
                  len_nxt = has_data ? cmd_len : 9'h000;
                  idx_nxt = 2'h0;
                  cnt_nxt = 9'h000;
                  cs_n_nxt = 1'b0;
                  state_nxt = ST_HEAD;
               end
            end
         end
         ST_HEAD: begin
            if (tx_ready) begin
               idx_nxt = idx_r + 2'h1;
               if (idx_r == 2'(flash_prog_pkg::ADDR_BYTES)) begin
                  state_nxt = kind_r[1] ? ST_DATA : ST_END;
               end
            end
         end
         ST_DATA: begin
            if (tx_valid && tx_ready) begin
               cnt_nxt = cnt_r + 9'h001;
               // Only the requested count goes out; with 02h the device
               // programs just those bytes, with 82h/85h the whole buffer page
               if (cnt_r + 9'h001 == len_r) begin
                  state_nxt = ST_END;
               end
            end
         end
         ST_END: begin
            // CS rises only once the last bit has fully shifted
            if (tx_ready) begin
               cs_n_nxt = 1'b1;
               state_nxt = ST_WAIT;
               unique case (kind_r)
                  flash_prog_pkg::KIND_PROG_NOERASE:
                     wait_nxt = 24'(P_CYC);
                  flash_prog_pkg::KIND_BYTE_PROG:
                     wait_nxt = 24'(len_r * BP_CYC);
                  default:
                     wait_nxt = 24'(EP_CYC);
               endcase
            end
         end
         ST_WAIT: begin
            // Self-timed operation in the device; hold off all commands
            if (wait_r == 24'h00_0000) begin
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end else begin
               wait_nxt = wait_r - 24'h00_0001;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         kind_r <= 2'h0;
         op_r <= 8'h00;
         addr_r <= 24'h00_0000;
         idx_r <= 2'h0;
         len_r <= 9'h000;
         cnt_r <= 9'h000;
         wait_r <= 24'h00_0000;
         cs_n_r <= 1'b1;
         done_r <= 1'b0;
         rej_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         idx_r <= idx_nxt;
         len_r <= len_nxt;
         cnt_r <= cnt_nxt;
         wait_r <= wait_nxt;
         cs_n_r <= cs_n_nxt;
         done_r <= done_nxt;
         rej_r <= rej_nxt;
      end
   end

   assign spi_cs_n = cs_n_r;
   assign cmd_done = done_r;
   assign cmd_reject = rej_r;
   assign flash_busy = (state_r == ST_WAIT);

   AST_OP_ERASE: assert property (@(posedge core_clk)
      disable iff (rst) take && !len_bad && cmd_kind == 2'h0 |=>
      op_r == ($past(cmd_buf_two) ? 8'h86 : 8'h83))
      else $error("Wrong opcode for program with erase");
   AST_OP_NOERASE: assert property (@(posedge core_clk)
      disable iff (rst) take && !len_bad && cmd_kind == 2'h1 |=>
      op_r == ($past(cmd_buf_two) ? 8'h89 : 8'h88))
      else $error("Wrong opcode for program without erase");
   AST_OP_LOAD: assert property (@(posedge core_clk)
      disable iff (rst) take && !len_bad && cmd_kind == 2'h2 |=>
      op_r == ($past(cmd_buf_two) ? 8'h85 : 8'h82))
      else $error("Wrong opcode for load and program");
   AST_ADDR_STD: assert property (@(posedge core_clk)
      disable iff (rst) take && !len_bad && !binary_mode |=>
      addr_r[23:20] == 4'h0 && addr_r[19:9] == $past(page_number_bits))
      else $error("Standard page address misplaced");
   AST_ADDR_BIN: assert property (@(posedge core_clk)
      disable iff (rst) take && !len_bad && binary_mode |=>
      addr_r[23:19] == 5'h00 && addr_r[18:8] == $past(page_number_bits))
      else $error("Binary page address misplaced");
   AST_START_ADDR: assert property (@(posedge core_clk)
      disable iff (rst) take && !len_bad && cmd_kind[1] && !binary_mode |=>
      addr_r[8:0] == $past(cmd_start_addr))
      else $error("Buffer start address not sent");
   AST_CS_WHOLE_BYTES: assert property (@(posedge core_clk)
      disable iff (rst)
      $rose(cs_n_r) |-> $past(tx_ready) && $past(state_r) == ST_END)
      else $error("CS rose inside a byte");
   AST_DATA_COUNT: assert property (@(posedge core_clk)
      disable iff (rst)
      state_r == ST_DATA && state_nxt == ST_END |-> cnt_r + 9'h001 == len_r)
      else $error("Data byte count mismatch");
   AST_BYTE_WAIT: assert property (@(posedge core_clk)
      disable iff (rst) state_r == ST_END && tx_ready && kind_r == 2'h3 |=>
      wait_r == 24'($past(len_r) * BP_CYC))
      else $error("Byte program wait not scaled");
   AST_NO_CMD_BUSY: assert property (@(posedge core_clk)
      disable iff (rst) state_r == ST_WAIT |-> !cmd_ready && cs_n_r)
      else $error("Command accepted while device busy");
endmodule

// File: core/spi_byte_tx.sv
// SPI mode-0 byte shifter, MSB first, generating SCK from core_clk.
// Assumes the caller holds chip select low around a run of bytes.
`timescale 1ns/1ps
module spi_byte_tx (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready,
   output logic spi_sck,
   output logic spi_mosi
);
   logic busy_r, busy_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [1:0] ph_r, ph_nxt;
   logic sck_r, sck_nxt;

   always_comb begin
      busy_nxt = busy_r;
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      ph_nxt = ph_r;
      sck_nxt = 1'b0;
      if (!busy_r) begin
         if (tx_valid) begin
            busy_nxt = 1'b1;
            sh_nxt = tx_byte;
            bit_nxt = 3'h0;
            ph_nxt = 2'h0;
         end
      end else begin
         ph_nxt = ph_r + 2'h1;
         // Rising edge in the middle of the bit, data stable before it
         sck_nxt = (ph_r >= 2'(flash_prog_pkg::SCK_HALF_CYC - 1)) &&
                   (ph_r != 2'h3);
         if (ph_r == 2'h3) begin
            sh_nxt = {sh_r[6:0], 1'b0};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
               busy_nxt = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy_r <= 1'b0;
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         ph_r <= 2'h0;
         sck_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         ph_r <= ph_nxt;
         sck_r <= sck_nxt;
      end
   end

   assign tx_ready = !busy_r;
   assign spi_sck = sck_r;
   assign spi_mosi = sh_r[7];

   AST_SCK_IDLE_LOW: assert property (@(posedge core_clk)
      disable iff (rst) !busy_r |=> !sck_r)
      else $error("SCK toggled outside a byte");
endmodule

// File: include/flash_prog_pkg.sv
// Constants for the host-side buffer/page program sequencer.
// Assumes a 10 MHz core clock and an SPI mode-0 flash on the far side.
package flash_prog_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // Core cycles per SCK half period (SCK period 400 ns)
   localparam int SCK_HALF_CYC = 2;
   localparam logic [7:0] OP_PROG_ERASE_B1 = 8'h83;
   localparam logic [7:0] OP_PROG_ERASE_B2 = 8'h86;
   localparam logic [7:0] OP_PROG_NOERASE_B1 = 8'h88;
   localparam logic [7:0] OP_PROG_NOERASE_B2 = 8'h89;
   localparam logic [7:0] OP_LOAD_PROG_B1 = 8'h82;
   localparam logic [7:0] OP_LOAD_PROG_B2 = 8'h85;
   localparam logic [7:0] OP_BYTE_PROG = 8'h02;
   localparam logic [8:0] PAGE_BYTES_STD = 9'h108;
   localparam logic [8:0] PAGE_BYTES_BIN = 9'h100;
   localparam int ADDR_BYTES = 3;
   // Command kinds on the user port
   localparam logic [1:0] KIND_PROG_ERASE = 2'h0;
   localparam logic [1:0] KIND_PROG_NOERASE = 2'h1;
   localparam logic [1:0] KIND_LOAD_PROG = 2'h2;
   localparam logic [1:0] KIND_BYTE_PROG = 2'h3;
endpackage

// File: verif/flash_dev_model.sv
// Behavioural serial flash: two page buffers and a sparse main array.
// Assumes mode-0 SCK from the host, idle low, CS low for a whole frame.
`timescale 1ns/1ps
module flash_dev_model #(
   parameter int BUSY_NS = 400
) (
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   input wire logic binary_mode,
   output logic [7:0] rx_byte,
   output logic rx_stb,
   output logic busy,
   output logic prog_err,
   output int aborts
);
   logic [7:0] bufm [2][512];
   logic [7:0] mem [int];
   logic [7:0] sh;
   logic [7:0] fr [$];
   logic [23:0] a;
   logic [10:0] pg;
   logic b2;
   int nbits, st, sz, n, k;

   // Unwritten array bytes read as erased
   function automatic logic [7:0] rd(input int key);
      return mem.exists(key) ? mem[key] : 8'hff;
   endfunction

   initial begin
      rx_byte = 8'h00;
      rx_stb = 1'b0;
      busy = 1'b0;
      prog_err = 1'b0;
      aborts = 0;
      nbits = 0;
      foreach (bufm[i, j]) bufm[i][j] = 8'hff;
   end

   always @(negedge spi_cs_n) begin
      nbits = 0;
      fr.delete();
   end

   always @(posedge spi_sck) begin
      if (spi_cs_n === 1'b0) begin
         sh = {sh[6:0], spi_mosi};
         nbits++;
         if (nbits % 8 == 0) begin
            fr.push_back(sh);
            rx_byte = sh;
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
         end
      end
   end

   // Blocking delay while busy also drops any frame ending meanwhile
   always @(posedge spi_cs_n) begin
      if (!busy && fr.size() >= 4) begin
         if (nbits % 8 != 0) begin
            aborts++;
         end else begin
            a = {fr[1], fr[2], fr[3]};
            sz = binary_mode ? 256 : 264;
            pg = binary_mode ? a[18:8] : a[19:9];
            st = binary_mode ? int'(a[7:0]) : int'(a[8:0]);
            b2 = fr[0] inside {8'h86, 8'h89, 8'h85};
            n = fr.size() - 4;
            if (fr[0] != 8'h02) begin
               for (int i = 0; i < n; i++) begin
                  bufm[b2][(st + i) % sz] = fr[4 + i];
               end
               for (int i = 0; i < sz; i++) begin
                  k = pg * 512 + i;
                  if (!(fr[0] inside {8'h88, 8'h89})) mem[k] = 8'hff;
                  mem[k] = rd(k) & bufm[b2][i];
                  if (mem[k] !== bufm[b2][i]) prog_err = 1'b1;
               end
            end else begin
               for (int i = 0; i < n; i++) begin
                  k = pg * 512 + (st + i) % sz;
                  mem[k] = rd(k) & fr[4 + i];
               end
            end
            busy = 1'b1;
            #(BUSY_NS + (fr[0] == 8'h02 ? n : 0)) busy = 1'b0;
         end
      end
   end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the buffer/page program host sequencer.
// Assumes the flash model above on the far side of the SPI pins.
`timescale 1ns/1ps
module tb_top;
   logic core_clk, rst, binary_mode, cmd_valid, cmd_buf_two, data_valid;
   logic cmd_ready, data_ready, cmd_done, cmd_reject, flash_busy;
   logic spi_cs_n, spi_sck, spi_mosi, rx_stb, busy, prog_err;
   logic [1:0] cmd_kind;
   logic [10:0] page_number_bits;
   logic [8:0] cmd_start_addr, cmd_len;
   logic [7:0] data_byte, rx_byte;
   logic [7:0] expq [$];
   logic [7:0] ops [8] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85,
                           8'h02, 8'h02};
   int aborts, error_cnt, n_compared, cyc, busy_cyc;
   // Every self-timed time is set to one microsecond below, per byte for 02h
   localparam int US_CYC = 1000 / flash_prog_pkg::CLK_PERIOD_NS;

   buf_page_prog_host #(
      .ERASE_PLUS_PROGRAM_TIME_US(1),
      .PAGE_PROGRAM_TIME_US(1),
      .PER_BYTE_PROGRAM_TIME_US(1)
   ) buf_page_prog_host_inst (
      .core_clk(core_clk),
      .rst(rst),
      .binary_mode(binary_mode),
      .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready),
      .cmd_kind(cmd_kind),
      .cmd_buf_two(cmd_buf_two),
      .page_number_bits(page_number_bits),
      .cmd_start_addr(cmd_start_addr),
      .cmd_len(cmd_len),
      .data_valid(data_valid),
      .data_ready(data_ready),
      .data_byte(data_byte),
      .cmd_done(cmd_done),
      .cmd_reject(cmd_reject),
      .flash_busy(flash_busy),
      .spi_cs_n(spi_cs_n),
      .spi_sck(spi_sck),
      .spi_mosi(spi_mosi)
   );

   flash_dev_model flash_dev_model_inst (
      .spi_cs_n(spi_cs_n),
      .spi_sck(spi_sck),
      .spi_mosi(spi_mosi),
      .binary_mode(binary_mode),
      .rx_byte(rx_byte),
      .rx_stb(rx_stb),
      .busy(busy),
      .prog_err(prog_err),
      .aborts(aborts)
   );

   function automatic logic [7:0] arr(input int key);
      return flash_dev_model_inst.rd(key);
   endfunction

   always #50 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Timeout well above the longest expected run
   always @(posedge core_clk) begin
      cyc++;
      if (flash_busy === 1'b1)
         busy_cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         close_out();
      end
   end

   always @(posedge rx_stb) begin
      if (expq.size() == 0)
         check(32'h1, 32'h0);
      else
         check(rx_byte, expq.pop_front());
   end

   task automatic run(input logic [1:0] k, input logic b2,
                      input logic [10:0] pg, input int st, input int len,
                      input logic bin);
      logic [7:0] d [$];
      logic [23:0] ad;
      int sz, t, s, b0, nb, pb;
      logic ok;
      sz = bin ? 256 : 264;
      s = bin ? st % 256 : st;
      pb = pg * 512;
      ok = k < 2 || (len >= 1 && len <= sz);
      ad = bin ? {5'h00, pg, s[7:0] & {8{k[1]}}}
               : {4'h0, pg, s[8:0] & {9{k[1]}}};
      if (ok) begin
         expq.push_back(ops[{k, b2}]);
         expq.push_back(ad[23:16]);
         expq.push_back(ad[15:8]);
         expq.push_back(ad[7:0]);
      end
      @(posedge core_clk);
      #1;
      b0 = busy_cyc;
      binary_mode = bin;
      cmd_kind = k;
      cmd_buf_two = b2;
      page_number_bits = pg;
      cmd_start_addr = 9'(st);
      cmd_len = 9'(len);
      cmd_valid = 1'b1;
      do @(posedge core_clk); while (cmd_ready !== 1'b1);
      #1 cmd_valid = 1'b0;
      for (int i = 0; ok && k[1] && i < len; i++) begin
         d.push_back(8'($urandom));
         expq.push_back(d[i]);
         data_byte = d[i];
         data_valid = 1'b1;
         t = 0;
         do begin
            @(posedge core_clk);
            t++;
         end while (data_ready !== 1'b1 && t < 200);
         check(data_ready, 1'b1);
         // Ready stays low for a whole byte, so valid may stay up
         #1;
      end
      data_valid = 1'b0;
      t = 0;
      do begin
         @(posedge core_clk);
         t++;
      end while (cmd_done !== 1'b1 && cmd_reject !== 1'b1 && t < 20000);
      check(cmd_reject, !ok);
      check(cmd_done, ok);
      #1;
      // Busy covers the whole wait plus the cycle that ends it
      nb = ok ? (k == 3 ? len : 1) * US_CYC + 1 : 0;
      check(busy_cyc - b0, nb);
      check(expq.size(), 0);
      check(busy, 0);
      for (int i = 0; i < d.size(); i++) begin
         check(arr(pb + (s + i) % sz), d[i]);
      end
      if (ok && k == 3 && len < sz)
         check(arr(pb + (s + len) % sz), 8'hff);
   endtask

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {binary_mode, cmd_valid, cmd_buf_two, data_valid} = 4'h0;
      {cmd_kind, page_number_bits, cmd_start_addr, cmd_len} = 31'h0;
      data_byte = 8'h00;
      void'($urandom(32'haec4_0ad9));
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      check(spi_cs_n, 1);
      check(cmd_ready, 1);
      check(flash_busy, 0);
      for (int i = 0; i < 16; i++) begin
         run(i[1:0], i[2], {6'($urandom), 5'(i)}, $urandom_range(0, 263),
             $urandom_range(1, 5), i[3]);
      end
      run(2, 1, 11'h7f0, 262, 4, 0);
      run(3, 0, 11'h7f1, 5, 264, 0);
      run(3, 0, 11'h7f2, 255, 256, 1);
      run(3, 0, 11'h7f3, 0, 0, 0);
      run(2, 0, 11'h7f4, 0, 265, 0);
      run(3, 0, 11'h7f5, 0, 257, 1);
      check(prog_err, 0);
      check(aborts, 0);
      close_out();
   end
endmodule
